/* pxo_pixel_output.sv */
// pixel output stage: phase-shifted sampling, strobe clock, line sync
`timescale 1ns/1ns
`default_nettype none
module pxo_pixel_output #(
   parameter int DW = pxo_pkg::DATA_W
) (
   // control clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // link clock, phase step rate
   input  wire logic          pix_clk,
   // register port behind the serial decoder
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_we,
   input  wire logic          reg_re,
   output logic      [7:0]    reg_rdata,
   // converter words and sync pin
   input  wire logic [DW-1:0] adc_red,
   input  wire logic [DW-1:0] adc_green,
   input  wire logic [DW-1:0] adc_blue,
   input  wire logic          hsync_in,
   // outputs to capture logic
   output logic      [DW-1:0] red_out,
   output logic      [DW-1:0] green_out,
   output logic      [DW-1:0] blue_out,
   output logic               output_strobe_clock,
   output logic               regenerated_line_sync_out
);
   logic [4:0]  phase_q;
   logic [1:0]  sel_q;
   logic        pol_q;
   logic [7:0]  wid_q;
   logic        dirty_q;
   logic [7:0]  rdata_q;
   logic        prs1_q;
   logic        pix_rst_n;
   logic [4:0]  ph_q;
   pxo_pkg::pxo_strobe_sel_type psel_q;
   logic        ppol_q;
   logic [7:0]  pwid_q;
   logic [4:0]  tick_q;
   logic [4:0]  u;
   logic        samp;
   logic        hs1_q;
   logic        hs2_q;
   logic        hs_prev_q;
   logic        hs_edge;
   logic [7:0]  cnt_q;
   logic        hs_q;
   logic        half_q;
   logic        half_d;
   logic        strobe_q;
   logic        strobe_d;
   logic [DW-1:0] r_q;
   logic [DW-1:0] g_q;
   logic [DW-1:0] b_q;
   logic        cfg_wr;

   pxo_cfg_if #(.W(pxo_pkg::CFG_W)) cfg_bus ();

   pxo_cfg_xfer u_xfer (
      .clk       (clk),
      .rst_n     (rst_n),
      .pix_clk   (pix_clk),
      .pix_rst_n (pix_rst_n),
      .cfg       (cfg_bus.xfer)
   );

   // register writes
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         phase_q <= pxo_pkg::PHASE_RST[pxo_pkg::PHASE_HI:pxo_pkg::PHASE_LO];
         sel_q   <= pxo_pkg::CLKSEL_RST[pxo_pkg::SEL_HI:pxo_pkg::SEL_LO];
         pol_q   <= pxo_pkg::HSCTL_RST[pxo_pkg::POL_BIT];
         wid_q   <= pxo_pkg::HSWID_RST;
      end
      else if (reg_we)
      begin
         unique case (reg_addr)
            pxo_pkg::PHASE_OFS:
               phase_q <= reg_wdata[pxo_pkg::PHASE_HI:pxo_pkg::PHASE_LO];
            pxo_pkg::CLKSEL_OFS:
               sel_q <= reg_wdata[pxo_pkg::SEL_HI:pxo_pkg::SEL_LO];
            pxo_pkg::HSCTL_OFS:  pol_q <= reg_wdata[pxo_pkg::POL_BIT];
            pxo_pkg::HSWID_OFS:  wid_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   assign cfg_wr = reg_we && (reg_addr == pxo_pkg::PHASE_OFS ||
                   reg_addr == pxo_pkg::CLKSEL_OFS ||
                   reg_addr == pxo_pkg::HSCTL_OFS ||
                   reg_addr == pxo_pkg::HSWID_OFS);

   // pending flag: a new write wins over the launch clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         dirty_q <= 1'b0;
      else if (cfg_wr)
         dirty_q <= 1'b1;
      else if (!cfg_bus.src_busy)
         dirty_q <= 1'b0;
   end

   assign cfg_bus.src_load = dirty_q && !cfg_wr;
   assign cfg_bus.src_data = {phase_q, sel_q, pol_q, wid_q};

   // register reads, unmapped offsets read zero
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata_q <= 8'h00;
      else if (reg_re)
      begin
         unique case (reg_addr)
            pxo_pkg::PHASE_OFS:  rdata_q <= {phase_q, 3'h0};
            pxo_pkg::CLKSEL_OFS: rdata_q <= {sel_q, 6'h00};
            pxo_pkg::HSCTL_OFS:  rdata_q <= {7'h00, pol_q};
            pxo_pkg::HSWID_OFS:  rdata_q <= wid_q;
            pxo_pkg::STATUS_OFS:
               rdata_q <= {6'h00, cfg_bus.src_busy, dirty_q};
            default:             rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_q;

   // reset level carried into the link domain
   always_ff @(posedge pix_clk)
   begin
      prs1_q    <= rst_n;
      pix_rst_n <= prs1_q;
   end

   // applied configuration in the link domain
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_n)
      begin
         ph_q   <= pxo_pkg::PHASE_RST[pxo_pkg::PHASE_HI:pxo_pkg::PHASE_LO];
         psel_q <= pxo_pkg::pxo_strobe_sel_type'(
                   pxo_pkg::CLKSEL_RST[pxo_pkg::SEL_HI:pxo_pkg::SEL_LO]);
         ppol_q <= pxo_pkg::HSCTL_RST[pxo_pkg::POL_BIT];
         pwid_q <= pxo_pkg::HSWID_RST;
      end
      else if (cfg_bus.dst_valid)
      begin
         ph_q   <= cfg_bus.dst_data[15:11];
         psel_q <= pxo_pkg::pxo_strobe_sel_type'(cfg_bus.dst_data[10:9]);
         ppol_q <= cfg_bus.dst_data[8];
         pwid_q <= cfg_bus.dst_data[7:0];
      end
   end

   // step counter; position within the pixel relative to the phase
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_n)
         tick_q <= 5'h00;
      else
         tick_q <= tick_q + 5'h01;
   end

   assign u    = tick_q - ph_q;
   assign samp = (u == 5'h00);

   // sync pin through two flops
   always_ff @(posedge pix_clk)
   begin
      hs1_q <= hsync_in;
      hs2_q <= hs1_q;
   end

   // sampling and output words, one step after the sample instant
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_n)
      begin
         r_q <= '0;
         g_q <= '0;
         b_q <= '0;
      end
      else if (samp)
      begin
         r_q <= adc_red;
         g_q <= adc_green;
         b_q <= adc_blue;
      end
   end

   assign hs_edge = hs2_q && !hs_prev_q;

   // line sync regenerated on the same sample step as the data
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_n)
      begin
         hs_prev_q <= 1'b0;
         cnt_q     <= 8'h00;
         hs_q      <= !pxo_pkg::HSCTL_RST[pxo_pkg::POL_BIT];
      end
      else if (samp)
      begin
         hs_prev_q <= hs2_q;
         if (hs_edge && pwid_q != 8'h00)
         begin
            cnt_q <= pwid_q - 8'h01;
            hs_q  <= ppol_q;
         end
         else if (cnt_q != 8'h00)
         begin
            cnt_q <= cnt_q - 8'h01;
            hs_q  <= ppol_q;
         end
         else
            hs_q  <= !ppol_q;
      end
   end

   // strobe choice, decoded from the step position
   always_comb
   begin
      half_d = (u == pxo_pkg::HALF_FLIP) ? !half_q : half_q;
      unique case (psel_q)
         pxo_pkg::SEL_PIXEL:  strobe_d = u[4];
         pxo_pkg::SEL_QUAD:   strobe_d = u[4] ^ u[3];
         pxo_pkg::SEL_DOUBLE: strobe_d = u[3];
         pxo_pkg::SEL_HALF:   strobe_d = half_d;
      endcase
   end

   // strobe register; rises at step 16 pixel, 8 quadrature, 8 and 24 double; half rate flips at 15
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_n)
      begin
         half_q   <= 1'b0;
         strobe_q <= 1'b0;
      end
      else
      begin
         half_q   <= half_d;
         strobe_q <= strobe_d;
      end
   end

   assign red_out                   = r_q;
   assign green_out                 = g_q;
   assign blue_out                  = b_q;
   assign output_strobe_clock       = strobe_q;
   assign regenerated_line_sync_out = hs_q;

   // checks in the link domain; a new configuration takes two steps to
   // settle in the strobe, so edges right after it are not judged
   sequence s_sample;
      samp;
   endsequence

   sequence s_hs_start;
      samp && hs_edge && pwid_q != 8'h00;
   endsequence

   a_data_latency: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      s_sample |=> red_out == $past(adc_red) && blue_out == $past(adc_blue))
      else $error("output word not the sampled word");
   a_data_timing: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      $changed(green_out) |-> $past(tick_q) == $past(ph_q))
      else $error("data moved off the phase step");
   a_pixel_strobe: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      (psel_q == pxo_pkg::SEL_PIXEL && $rose(strobe_q)
       && !$past(cfg_bus.dst_valid) && !$past(cfg_bus.dst_valid, 2))
      |-> $past(u) == pxo_pkg::PIX_MID)
      else $error("pixel strobe edge misplaced");
   a_quad_strobe: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      (psel_q == pxo_pkg::SEL_QUAD && $rose(strobe_q)
       && !$past(cfg_bus.dst_valid) && !$past(cfg_bus.dst_valid, 2))
      |-> $past(u) == pxo_pkg::QUAD_RISE)
      else $error("quadrature strobe edge misplaced");
   a_double_strobe: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      (psel_q == pxo_pkg::SEL_DOUBLE && $rose(strobe_q)
       && !$past(cfg_bus.dst_valid) && !$past(cfg_bus.dst_valid, 2))
      |-> $past(u) == pxo_pkg::QUAD_RISE || $past(u) == pxo_pkg::DBL_RISE2)
      else $error("double rate strobe edge misplaced");
   a_half_strobe: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      (psel_q == pxo_pkg::SEL_HALF && $changed(strobe_q)
       && !$past(cfg_bus.dst_valid) && !$past(cfg_bus.dst_valid, 2))
      |-> $past(u) == pxo_pkg::HALF_FLIP)
      else $error("half rate strobe edge misplaced");
   a_sync_start: assert property (@(posedge pix_clk) disable iff (!pix_rst_n)
      s_hs_start ##0 !cfg_bus.dst_valid |=> regenerated_line_sync_out == ppol_q)
      else $error("line sync did not start");

   // checks in the control domain
   a_phase_write: assert property (@(posedge clk) disable iff (!rst_n)
      reg_we && reg_addr == pxo_pkg::PHASE_OFS
      |=> phase_q == $past(reg_wdata[7:3]) && dirty_q)
      else $error("phase write not held");
   a_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
      reg_we && reg_addr == pxo_pkg::CLKSEL_OFS
      |=> sel_q == $past(reg_wdata[7:6]))
      else $error("select write not held");
   a_sel_reset: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> sel_q == 2'h0)
      else $error("select not pixel clock after reset");
endmodule // pxo_pixel_output
`default_nettype wire

/* pxo_pkg.sv */
// shared constants and types of the pixel output alignment block
package pxo_pkg;
   // register offsets on the internal register port
   localparam logic [7:0] PHASE_OFS   = 8'h04;
   localparam logic [7:0] CLKSEL_OFS  = 8'h20;
   localparam logic [7:0] HSCTL_OFS   = 8'h21;
   localparam logic [7:0] HSWID_OFS   = 8'h22;
   localparam logic [7:0] STATUS_OFS  = 8'h23;
   // field positions
   localparam int         PHASE_HI    = 7;
   localparam int         PHASE_LO    = 3;
   localparam int         SEL_HI      = 7;
   localparam int         SEL_LO      = 6;
   localparam int         POL_BIT     = 0;
   // reset values
   localparam logic [7:0] PHASE_RST   = 8'h00;
   localparam logic [7:0] CLKSEL_RST  = 8'h00;
   localparam logic [7:0] HSCTL_RST   = 8'h01;
   localparam logic [7:0] HSWID_RST   = 8'h20;
   // timing and word width: link ticks per pixel, one tick per phase step
   localparam int         PHASE_W     = 5;
   localparam int         DATA_W      = 10;
   localparam logic [4:0] PIX_MID     = 5'h10;
   localparam logic [4:0] QUAD_RISE   = 5'h08;
   localparam logic [4:0] DBL_RISE2   = 5'h18;
   localparam logic [4:0] HALF_FLIP   = 5'h0F;
   // configuration word carried into the link domain
   localparam int         CFG_W       = 16;
   // strobe clock choices
   typedef enum logic [1:0] {
      SEL_PIXEL  = 2'b00,
      SEL_QUAD   = 2'b01,
      SEL_DOUBLE = 2'b10,
      SEL_HALF   = 2'b11
   } pxo_strobe_sel_type;
endpackage

/* pxo_cfg_if.sv */
// configuration crossing signals between control and link domains
`timescale 1ns/1ns
`default_nettype none
interface pxo_cfg_if #(parameter int W = 16);
   logic [W-1:0] src_data;
   logic         src_load;
   logic         src_busy;
   logic [W-1:0] dst_data;
   logic         dst_valid;
   modport ctrl (output src_data, output src_load, input src_busy,
                 input dst_data, input dst_valid);
   modport xfer (input src_data, input src_load, output src_busy,
                 output dst_data, output dst_valid);
endinterface
`default_nettype wire

/* pxo_cfg_xfer.sv */
// toggle handshake that moves a configuration word into the link domain
`timescale 1ns/1ns
`default_nettype none
module pxo_cfg_xfer (
   // control domain
   input  wire logic clk,
   input  wire logic rst_n,
   // link domain
   input  wire logic pix_clk,
   input  wire logic pix_rst_n,
   // crossing signals
   pxo_cfg_if.xfer   cfg
);
   logic [15:0] hold_q;
   logic        req_q;
   logic        ack_s1_q;
   logic        ack_s2_q;
   logic        req_s1_q;
   logic        req_s2_q;
   logic        req_s3_q;
   logic        ack_q;
   logic [15:0] dst_q;
   logic        vld_q;

   // source side: hold word stable while a toggle is outstanding
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         hold_q <= 16'h0000;
         req_q  <= 1'b0;
      end
      else if (cfg.src_load && !cfg.src_busy)
      begin
         hold_q <= cfg.src_data;
         req_q  <= ~req_q;
      end
   end

   // acknowledge returns through two flops
   always_ff @(posedge clk)
   begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
   end

   assign cfg.src_busy = req_q ^ ack_s2_q;

   // destination side: edge of synced toggle captures the held word
   always_ff @(posedge pix_clk)
   begin
      if (!pix_rst_n)
      begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
         ack_q    <= 1'b0;
         dst_q    <= 16'h0000;
         vld_q    <= 1'b0;
      end
      else
      begin
         req_s1_q <= req_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
         ack_q    <= req_s2_q;
         vld_q    <= req_s2_q ^ req_s3_q;
         if (req_s2_q ^ req_s3_q)
            dst_q <= hold_q;
      end
   end

   assign cfg.dst_data  = dst_q;
   assign cfg.dst_valid = vld_q;
endmodule // pxo_cfg_xfer
`default_nettype wire

/* pxo_capture_model.sv */
// capture logic model that latches pixel words on the strobe clock
`timescale 1ns/1ns
`default_nettype none
module pxo_capture_model (
   // lines from the pixel output stage
   input  wire logic       strobe,
   input  wire logic [9:0] red,
   input  wire logic [9:0] green,
   input  wire logic       sync,
   // words as captured downstream
   output logic      [9:0] cap_red,
   output logic      [9:0] cap_green,
   output logic            cap_sync
);
   // latch data and line sync on the rising strobe edge only
   always_ff @(posedge strobe)
   begin
      cap_red   <= red;
      cap_green <= green;
      cap_sync  <= sync;
   end
endmodule // pxo_capture_model
`default_nettype wire

/* pixel_output_clock_alignment_tb_top.sv */
// self-checking bench of the pixel output stage
`timescale 1ns/1ns
`default_nettype none
module pixel_output_clock_alignment_tb_top;
   logic        clk, pix_clk, rst_n, reg_we, reg_re, hsync_in, pol, lat_en;
   logic        strobe, sync_out, cap_sync, prev_strobe, prev_sync;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [9:0]  t_q, red_out, green_out, blue_out, cap_red, cap_green;
   logic [9:0]  last_val;
   logic [4:0]  s0;
   logic [31:0] mask;
   int          n_fail, checks_done, k, rises, act, n_pix, cyc, sync_skew;
   logic [31:0] exp_mask [4] = '{32'h0001_0000, 32'h0000_0100,
                                 32'h0100_0100, 32'h0000_8000};
   logic [7:0]  wid_tab [3] = '{8'h03, 8'h03, 8'h00};

   // design under test with default channel width
   pxo_pixel_output dut (
      .clk(clk), .rst_n(rst_n), .pix_clk(pix_clk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata),
      .adc_red(t_q), .adc_green(~t_q), .adc_blue(t_q + 10'h155),
      .hsync_in(hsync_in), .red_out(red_out), .green_out(green_out),
      .blue_out(blue_out), .output_strobe_clock(strobe),
      .regenerated_line_sync_out(sync_out));

   // downstream capture logic
   pxo_capture_model cap (
      .strobe(strobe), .red(red_out), .green(green_out), .sync(sync_out),
      .cap_red(cap_red), .cap_green(cap_green), .cap_sync(cap_sync));

   // control clock and an unrelated link clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      pix_clk = 1'b0;
      #7;
      forever #15 pix_clk = ~pix_clk;
   end

   // converter words step once per link tick so each sample is traceable
   always @(posedge pix_clk)
      t_q <= t_q + 10'h001;

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic reg_write(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge clk);
      reg_we    <= 1'b0;
   endtask

   task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_re   <= 1'b1;
      @(posedge clk);
      reg_re   <= 1'b0;
      #1 check("register read", {24'h0, reg_rdata}, {24'h0, exp});
   endtask

   // waits for a pixel boundary, clears the tallies, then spans np pixels
   task automatic window(int np);
      int w;
      w = n_pix + 1;
      while (n_pix < w) begin @(negedge pix_clk); #1; end
      rises = 0;
      mask  = 32'h0;
      w     = n_pix + np;
      while (n_pix < w) begin @(negedge pix_clk); #1; end
   endtask

   // output monitor: latency, strobe position, sync alignment and width
   always @(negedge pix_clk)
   begin
      if (red_out !== last_val)
      begin
         if (lat_en)
         begin
            // the word was sampled one converter step before the change
            check("red", red_out, 10'(t_q - 10'h001));
            check("green", green_out, 10'(~(t_q - 10'h001)));
            check("blue", blue_out, 10'(t_q + 10'h154));
         end
         last_val = red_out;
         k        = 0;
         n_pix++;
      end
      else
         k++;
      if (strobe === 1'b1 && prev_strobe === 1'b0 && k < 32)
      begin
         rises++;
         mask[k] = 1'b1;
      end
      if (sync_out !== prev_sync && k != 0)
         sync_skew++;
      if (sync_out === pol)
         act++;
      prev_strobe = strobe;
      prev_sync   = sync_out;
   end

   // hang guard on the control clock
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_fail++;
         test_done();
      end
   end

   // main sequence
   initial
   begin
      rst_n = 1'b0; reg_we = 1'b0; reg_re = 1'b0; hsync_in = 1'b0;
      reg_addr = 8'h00; reg_wdata = 8'h00; t_q = 10'h000; pol = 1'b1;
      lat_en = 1'b0; last_val = 10'h000; mask = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_chk(pxo_pkg::PHASE_OFS, 8'h00);
      rd_chk(pxo_pkg::CLKSEL_OFS, 8'h00);
      rd_chk(pxo_pkg::HSCTL_OFS, 8'h01);
      rd_chk(pxo_pkg::HSWID_OFS, 8'h20);
      rd_chk(8'h10, 8'h00);
      reg_write(pxo_pkg::PHASE_OFS, 8'hFF);
      reg_write(pxo_pkg::CLKSEL_OFS, 8'hFF);
      reg_write(8'h10, 8'hFF);
      rd_chk(pxo_pkg::PHASE_OFS, 8'hF8);
      rd_chk(pxo_pkg::CLKSEL_OFS, 8'hC0);
      rd_chk(8'h10, 8'h00);
      // let phase 31 settle so the first shift has a known start
      repeat (150) @(posedge clk);
      rd_chk(pxo_pkg::STATUS_OFS, 8'h00);
      // every strobe choice, at two sampling phases: 31 to 0, then 0 to 8
      for (int p = 0; p < 2; p++)
      begin
         lat_en = 1'b0;
         s0 = last_val[4:0];
         reg_write(pxo_pkg::PHASE_OFS, (p == 1) ? 8'h40 : 8'h00);
         reg_write(pxo_pkg::CLKSEL_OFS, 8'h00);
         repeat (150) @(posedge clk);
         window(2);
         // 31 to 0 wraps forward by one step, 0 to 8 moves by eight
         s0 = 5'(last_val[4:0] - s0);
         check("phase shift", s0, (p == 1) ? 8 : 1);
         lat_en = 1'b1;
         for (int s = 0; s < 4; s++)
         begin
            reg_write(pxo_pkg::CLKSEL_OFS, {s[1:0], 6'h00});
            repeat (150) @(posedge clk);
            window(8);
            check("strobe rises", rises, (s == 2) ? 16 : (s == 3) ? 4 : 8);
            check("strobe place", mask, exp_mask[s]);
            // half rate rises only every other pixel: wait for one that did
            while (k != 20 || (s == 3 && strobe !== 1'b1))
            begin
               @(negedge pix_clk);
               #1;
            end
            check("captured", {22'h0, cap_red}, {22'h0, red_out});
            check("captured sync", cap_sync, sync_out);
         end
      end
      // line sync: width, polarity and zero width
      for (int c = 0; c < 3; c++)
      begin
         pol = (c != 1);
         reg_write(pxo_pkg::HSWID_OFS, wid_tab[c]);
         reg_write(pxo_pkg::HSCTL_OFS, {7'h00, pol});
         // second word waits pending behind the crossing still busy
         rd_chk(pxo_pkg::STATUS_OFS, 8'h03);
         repeat (150) @(posedge clk);
         check("sync idle", {31'h0, sync_out}, {31'h0, ~pol});
         act = 0;
         sync_skew = 0;
         // hold the pin over two pixels so a sample step sees it high
         @(posedge pix_clk);
         hsync_in <= 1'b1;
         repeat (64) @(posedge pix_clk);
         hsync_in <= 1'b0;
         repeat (300) @(posedge clk);
         check("sync ticks", act, wid_tab[c] * 32);
         check("sync skew", sync_skew, 0);
      end
      test_done();
   end
endmodule // pixel_output_clock_alignment_tb_top
`default_nettype wire
